// [design/scict_pkg.sv]
// scict_pkg: constants and carriers for the serial control-two block
// assumes: 20 MHz system clock, avalon-mm register slave with 32-bit data
package scict_pkg;
  // register byte addresses (word aligned)
  localparam logic [3:0] SCICT_OFF_CTRL2 = 4'h0;
  localparam logic [3:0] SCICT_OFF_CTRL1 = 4'h4;
  localparam logic [3:0] SCICT_OFF_STAT = 4'h8;
  localparam logic [3:0] SCICT_OFF_EVT = 4'hc;
  // control-two bit positions
  localparam int SCICT_B_TX_EMPTY_IE = 7;
  localparam int SCICT_B_TX_DONE_IE = 6;
  localparam int SCICT_B_RX_IE = 5;
  localparam int SCICT_B_QUIET_IE = 4;
  localparam int SCICT_B_XMIT_ON = 3;
  localparam int SCICT_B_RCV_ON = 2;
  localparam int SCICT_B_MUTE = 1;
  localparam int SCICT_B_BREAK = 0;
  // control-one: wake method select position
  localparam int SCICT_B_WAKE_SEL = 3;
  // status bit positions
  localparam int SCICT_S_TXE = 7;
  localparam int SCICT_S_TXD = 6;
  localparam int SCICT_S_RXF = 5;
  localparam int SCICT_S_IDLE = 4;
  localparam int SCICT_S_OVR = 3;
  // reset values
  localparam logic [7:0] SCICT_CTRL2_RST = 8'h00;
  localparam logic [7:0] SCICT_CTRL1_RST = 8'h00;
  localparam logic [3:0] SCICT_EVT_RST = 4'h0;
  // bit timing
  localparam int SCICT_CLK_HZ = 20000000;
  localparam int SCICT_BAUD = 9600;
  localparam int SCICT_BIT_CYC = SCICT_CLK_HZ / SCICT_BAUD;
  localparam int SCICT_FRAME_BITS = 10;
  localparam int SCICT_IDLE_RX_BITS = 10;
  localparam logic [11:0] SCICT_BIT_LAST = 12'(SCICT_BIT_CYC - 1);
  localparam logic [3:0] SCICT_FRAME_LAST = 4'(SCICT_FRAME_BITS - 1);

  typedef struct packed {
    logic tx_empty_irq_en;
    logic tx_done_irq_en;
    logic rx_irq_en;
    logic quiet_line_irq_en;
    logic xmit_on;
    logic rcv_on;
    logic mute_request;
    logic break_send;
  } scict_ctrl_t;

  typedef struct packed {
    logic tx_buffer_empty_flag;
    logic tx_done_flag;
    logic rx_full_flag;
    logic idle_flag;
    logic overrun_flag;
  } scict_stat_t;

  typedef enum logic [1:0] {SCICT_TX_OFF, SCICT_TX_DELAY, SCICT_TX_IDLE, SCICT_TX_SEND} scict_txst_t;
endpackage : scict_pkg

// [design/scict_rx_watch.sv]
// scict_rx_watch: watches the synchronised rx line for idle and wake events
// assumes: i_rx is already synchronised; simple start-bit detector only
`timescale 1ns/1ps
module scict_rx_watch
  import scict_pkg::*;
(
  input wire logic i_clk_sys, // system clock
  input wire logic i_sys_rst, // sync reset, high
  input wire logic i_rcv_on, // receiver enabled
  input wire logic i_rx, // synchronised rx line
  output logic o_start, // pulse: start bit seen
  output logic o_idle // pulse: idle frame seen after data
);
  logic rx_d_reg;
  logic [15:0] quiet_cnt_reg;
  logic seen_data_reg;
  localparam logic [15:0] IDLE_CYC = 16'(SCICT_BIT_CYC * SCICT_IDLE_RX_BITS);

  // falling edge of line starts a search hit only while enabled
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rx_d_reg <= 1'b1;
      o_start <= 1'b0;
    end else begin
      rx_d_reg <= i_rx;
      o_start <= i_rcv_on & rx_d_reg & ~i_rx;
    end
  end

  // idle detection only armed once some data was seen
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !i_rcv_on) begin
      quiet_cnt_reg <= 16'h0000;
      seen_data_reg <= 1'b0;
      o_idle <= 1'b0;
    end else begin
      o_idle <= 1'b0;
      if (!i_rx) begin
        quiet_cnt_reg <= 16'h0000;
        seen_data_reg <= 1'b1;
      end else if (seen_data_reg) begin
        if (quiet_cnt_reg == IDLE_CYC - 16'h0001) begin
          o_idle <= 1'b1;
          seen_data_reg <= 1'b0;
          quiet_cnt_reg <= 16'h0000;
        end else begin
          quiet_cnt_reg <= quiet_cnt_reg + 16'h0001;
        end
      end
    end
  end
endmodule : scict_rx_watch

// [design/scict_sync.sv]
// scict_sync: two-flop synchroniser for the serial receive pin
// assumes: input is asynchronous to i_clk_sys
`timescale 1ns/1ps
module scict_sync
  import scict_pkg::*;
(
  input wire logic i_clk_sys, // system clock
  input wire logic i_sys_rst, // sync reset, high
  input wire logic i_async, // raw pin
  output logic o_sync // synchronised level
);
  logic meta_reg;
  // line idles high, so reset to mark
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      meta_reg <= 1'b1;
      o_sync <= 1'b1;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule : scict_sync

// [design/scict_top.sv]
// scict_top: serial control-two register, interrupt gating, tx enable/break/preamble
// assumes: avalon-mm master on i_clk_sys; status flags come from same-clock logic
//
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module scict_top
  import scict_pkg::*;
(
  input wire logic i_clk_sys, // system clock, 20 MHz
  input wire logic i_sys_rst, // sync reset, high
  input wire logic [3:0] i_avs_address, // byte address
  input wire logic i_avs_read, // read request
  input wire logic i_avs_write, // write request
  input wire logic [31:0] i_avs_writedata, // write data
  input wire logic [3:0] i_avs_byteenable, // byte lanes
  output logic [31:0] o_avs_readdata, // read data
  output logic o_avs_waitrequest, // stall
  input wire scict_stat_t i_stat, // status flags, same clock
  input wire logic i_addr_mark, // pulse: address-mark wake seen
  input wire logic i_rx_pin, // raw rx pin
  output logic o_irq, // serial interrupt, level
  output logic o_tx_pin, // tx line level
  output logic o_tx_oe, // tx pin owned by serial block
  output logic o_rcv_active, // receiver on and not muted
  output logic o_tx_active // transmitter may shift data
);
  scict_ctrl_t ctrl_reg;
  logic [7:0] ctrl1_reg;
  logic [3:0] evt_reg;
  logic [3:0] evt_mask_reg;
  logic ack_reg;
  logic rx_sync;
  logic rx_start;
  logic rx_idle;
  logic ever_on_reg;
  logic preamble_req_reg;
  scict_txst_t tx_st_reg;
  logic [11:0] bit_cnt_reg;
  logic [3:0] frame_cnt_reg;
  logic brk_frame_reg;
  logic pre_frame_reg;
  logic [4:0] stat_d_reg;
  logic [3:0] evt_set;
  logic wr_hit;
  logic word_end;
  logic bit_tick;

  function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [31:0] wd, input logic [3:0] be);
    merge_byte = be[0] ? wd[7:0] : old_v;
  endfunction : merge_byte

  scict_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_async(i_rx_pin),
    .o_sync(rx_sync)
  );

  scict_rx_watch u_watch (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_rcv_on(ctrl_reg.rcv_on),
    .i_rx(rx_sync),
    .o_start(rx_start),
    .o_idle(rx_idle)
  );

  // one wait cycle per access; answer on the second edge
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
    end
  end
  assign wr_hit = i_avs_write & ack_reg;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & ~ack_reg);
    end
  end

  // read mux registered so data stands at the waitrequest-low edge
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      case (i_avs_address)
        SCICT_OFF_CTRL2: o_avs_readdata <= {24'h000000, ctrl_reg};
        SCICT_OFF_CTRL1: o_avs_readdata <= {24'h000000, ctrl1_reg};
        SCICT_OFF_STAT: o_avs_readdata <= {24'h000000, i_stat, 3'h0};
        SCICT_OFF_EVT: o_avs_readdata <= {20'h00000, evt_mask_reg, 4'h0, evt_reg};
        default: o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // control-two: software writes; hardware clears mute on wake
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ctrl_reg <= SCICT_CTRL2_RST;
    end else begin
      if (wr_hit && i_avs_address == SCICT_OFF_CTRL2) begin
        ctrl_reg <= merge_byte(ctrl_reg, i_avs_writedata, i_avs_byteenable);
      end
      // wake clears mute; a software write in the same cycle loses
      if (ctrl_reg.mute_request &&
          ((!ctrl1_reg[SCICT_B_WAKE_SEL] && rx_idle) || (ctrl1_reg[SCICT_B_WAKE_SEL] && i_addr_mark))) begin
        ctrl_reg.mute_request <= 1'b0;
      end
    end
  end

  // control-one copy: only the wake select is used here
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ctrl1_reg <= SCICT_CTRL1_RST;
    end else if (wr_hit && i_avs_address == SCICT_OFF_CTRL1) begin
      ctrl1_reg <= merge_byte(ctrl1_reg, i_avs_writedata, i_avs_byteenable);
    end
  end

  // rising edges of the ungated status flags set sticky events
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      stat_d_reg <= 5'h00;
    end else begin
      stat_d_reg <= i_stat;
    end
  end
  assign evt_set = {i_stat.tx_buffer_empty_flag & ~stat_d_reg[4],
                    i_stat.tx_done_flag & ~stat_d_reg[3],
                    (i_stat.rx_full_flag & ~stat_d_reg[2]) | (i_stat.overrun_flag & ~stat_d_reg[0]),
                    i_stat.idle_flag & ~stat_d_reg[1]};

  // sticky events, write one to clear; a new set wins over the clear
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      evt_reg <= SCICT_EVT_RST;
      evt_mask_reg <= SCICT_EVT_RST;
    end else begin
      if (wr_hit && i_avs_address == SCICT_OFF_EVT) begin
        // only lane 0 carries clear bits, so a mask-only write keeps pending events
        if (i_avs_byteenable[0]) begin
          evt_reg <= (evt_reg & ~i_avs_writedata[3:0]) | evt_set;
        end else begin
          evt_reg <= evt_reg | evt_set;
        end
        if (i_avs_byteenable[1]) begin
          evt_mask_reg <= i_avs_writedata[11:8];
        end
      end else begin
        evt_reg <= evt_reg | evt_set;
      end
    end
  end

  // level interrupt follows live flags gated by enables, plus unmasked events
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= (ctrl_reg.tx_empty_irq_en & i_stat.tx_buffer_empty_flag)
             | (ctrl_reg.tx_done_irq_en & i_stat.tx_done_flag)
             | (ctrl_reg.rx_irq_en & (i_stat.overrun_flag | i_stat.rx_full_flag))
             | (ctrl_reg.quiet_line_irq_en & i_stat.idle_flag)
             | (|(evt_reg & evt_mask_reg));
    end
  end

  // remembers whether the transmitter was ever on, for pin ownership
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ever_on_reg <= 1'b0;
    end else if (ctrl_reg.xmit_on) begin
      ever_on_reg <= 1'b1;
    end
  end

  // pin released only when both enables clear, or never enabled
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_tx_oe <= 1'b0;
    end else begin
      o_tx_oe <= ever_on_reg & (ctrl_reg.xmit_on | ctrl_reg.rcv_on);
    end
  end

  // receiver live only while enabled and not muted
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_rcv_active <= 1'b0;
    end else begin
      o_rcv_active <= ctrl_reg.rcv_on & ~ctrl_reg.mute_request;
    end
  end

  // bit and frame counters pace delay, preamble and break frames
  assign bit_tick = (bit_cnt_reg == SCICT_BIT_LAST);
  assign word_end = bit_tick && (frame_cnt_reg == SCICT_FRAME_LAST);
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || tx_st_reg == SCICT_TX_OFF || tx_st_reg == SCICT_TX_IDLE) begin
      bit_cnt_reg <= 12'h000;
      frame_cnt_reg <= 4'h0;
    end else if (bit_tick) begin
      bit_cnt_reg <= 12'h000;
      frame_cnt_reg <= (frame_cnt_reg == SCICT_FRAME_LAST) ? 4'h0 : frame_cnt_reg + 4'h1;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 12'h001;
    end
  end

  // an enable pulse during a word queues one preamble after it
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      preamble_req_reg <= 1'b0;
    end else if (tx_st_reg == SCICT_TX_SEND && !ctrl_reg.xmit_on) begin
      preamble_req_reg <= 1'b1;
    end else if (tx_st_reg == SCICT_TX_IDLE) begin
      preamble_req_reg <= 1'b0; // consumed as the idle frame starts, or dropped if turned off
    end
  end

  // preamble frame flag: the line stays marking and no data word is shifted
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pre_frame_reg <= 1'b0;
    end else if (tx_st_reg == SCICT_TX_IDLE) begin
      pre_frame_reg <= preamble_req_reg & ~ctrl_reg.break_send;
    end
  end

  // tx sequencer: delay one bit after enable, then shift/idle frames
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      tx_st_reg <= SCICT_TX_OFF;
      brk_frame_reg <= 1'b0;
    end else begin
      case (tx_st_reg)
        SCICT_TX_OFF: begin
          if (ctrl_reg.xmit_on) begin
            tx_st_reg <= SCICT_TX_DELAY;
          end
        end
        SCICT_TX_DELAY: begin
          if (bit_tick) begin
            tx_st_reg <= SCICT_TX_IDLE;
          end
        end
        SCICT_TX_IDLE: begin
          if (!ctrl_reg.xmit_on) begin
            tx_st_reg <= SCICT_TX_OFF;
          end else if (ctrl_reg.break_send || preamble_req_reg || i_stat.tx_buffer_empty_flag == 1'b0) begin
            brk_frame_reg <= ctrl_reg.break_send;
            tx_st_reg <= SCICT_TX_SEND;
          end
        end
        SCICT_TX_SEND: begin
          // the current word always finishes, even if disabled
          if (word_end) begin
            brk_frame_reg <= 1'b0;
            tx_st_reg <= (ctrl_reg.xmit_on && preamble_req_reg) ? SCICT_TX_DELAY : SCICT_TX_IDLE;
          end
        end
        default: tx_st_reg <= SCICT_TX_OFF;
      endcase
    end
  end

  // line level: zeros through a break frame, marking otherwise
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_tx_pin <= 1'b1;
    end else begin
      o_tx_pin <= ~(tx_st_reg == SCICT_TX_SEND && brk_frame_reg);
    end
  end

  // data frames only; break and preamble frames carry no word
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_tx_active <= 1'b0;
    end else begin
      o_tx_active <= (tx_st_reg == SCICT_TX_SEND) && !brk_frame_reg && !pre_frame_reg;
    end
  end
endmodule : scict_top

// [dv/scict_monitor.sv]
// scict_monitor: port-level assertions for the control-two block
// assumes: bound into scict_top, one clock, writes land when waitrequest is low
`timescale 1ns/1ps
module scict_monitor
  import scict_pkg::*;
(
  input wire logic i_clk_sys, // clock
  input wire logic i_sys_rst, // sync reset
  input wire logic [3:0] i_avs_address, // address
  input wire logic i_avs_write, // write
  input wire logic [31:0] i_avs_writedata, // write data
  input wire logic [3:0] i_avs_byteenable, // lanes
  input wire logic o_avs_waitrequest, // stall
  input wire scict_stat_t i_stat, // flags
  input wire logic o_irq, // interrupt
  input wire logic o_tx_pin, // tx level
  input wire logic o_tx_oe, // tx owned
  input wire logic o_rcv_active, // rx live
  input wire logic o_tx_active // tx frame
);
  localparam int BIT_MIN = SCICT_BIT_CYC - 8;
  logic [7:0] ctl_reg;
  logic ever_on_reg;
  logic [11:0] since_on_reg;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // shadow of control-two; hw mute clear is not seen, so mute is trusted only at 0
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ctl_reg <= 8'h00;
    end else if (i_avs_write && !o_avs_waitrequest && i_avs_address == SCICT_OFF_CTRL2 && i_avs_byteenable[0]) begin
      ctl_reg <= i_avs_writedata[7:0];
    end
  end
  // cycles since transmitter enable, saturating so long runs stay legal
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !ctl_reg[3]) begin
      since_on_reg <= 12'h000;
    end else if (since_on_reg != 12'hfff) begin
      since_on_reg <= since_on_reg + 12'h001;
    end
  end
  // transmitter enabled at least once since reset
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ever_on_reg <= 1'b0;
    end else if (ctl_reg[3]) begin
      ever_on_reg <= 1'b1;
    end
  end
  a_irq_tx_empty: assert property ((ctl_reg[7] && i_stat.tx_buffer_empty_flag) [*2] |-> o_irq)
    else $error("irq missing for tx empty");
  a_irq_tx_done: assert property ((ctl_reg[6] && i_stat.tx_done_flag) ##1 (ctl_reg[6] && i_stat.tx_done_flag) |-> o_irq)
    else $error("irq missing for tx done");
  a_irq_rx_data: assert property ((ctl_reg[5] && (i_stat.rx_full_flag || i_stat.overrun_flag)) [*2] |-> o_irq)
    else $error("irq missing for receive");
  a_irq_quiet_line: assert property ($past(ctl_reg[4] && i_stat.idle_flag) && ctl_reg[4] && i_stat.idle_flag |-> o_irq)
    else $error("irq missing for idle line");
  a_tx_start_delay: assert property ($rose(o_tx_active) |-> since_on_reg >= BIT_MIN)
    else $error("transmission began before one bit time");
  a_tx_mark_off: assert property ((!ctl_reg[3] && !o_tx_active) [*8] |-> o_tx_pin)
    else $error("tx line not marking while transmitter off");
  a_pin_owned: assert property ((ever_on_reg && (ctl_reg[3] || ctl_reg[2])) [*2] |-> o_tx_oe)
    else $error("tx pin released while an enable is set");
  a_pin_never_used: assert property ((!ever_on_reg) [*2] |-> !o_tx_oe)
    else $error("tx pin taken before transmitter was enabled");
  a_rcv_off: assert property ((!ctl_reg[2]) [*2] |-> !o_rcv_active)
    else $error("receiver active while disabled");
  a_rcv_on: assert property ((ctl_reg[2] && !ctl_reg[1]) [*2] |-> o_rcv_active)
    else $error("receiver idle while enabled and not muted");
  c_irq_rise: cover property ($rose(o_irq));
  c_tx_frame: cover property ($rose(o_tx_active));
  c_rcv_mute: cover property ($fell(o_rcv_active));
endmodule : scict_monitor

bind scict_top scict_monitor mon_u (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_waitrequest(o_avs_waitrequest), .i_stat(i_stat), .o_irq(o_irq), .o_tx_pin(o_tx_pin),
  .o_tx_oe(o_tx_oe), .o_rcv_active(o_rcv_active), .o_tx_active(o_tx_active));

// [dv/scict_remote.sv]
// scict_remote: far-side serial peer, sends frames toward rx and watches tx lows
// assumes: lines rest at mark through a pull-up, bit time from the package
`timescale 1ns/1ps
module scict_remote
  import scict_pkg::*;
(
  input wire logic i_clk_sys, // clock
  input wire logic i_tx_line, // resolved tx wire
  output logic o_rx_line // device rx line
);
  initial o_rx_line = 1'b1;
  // longest low run on tx over a window; only a break frame is that long
  task automatic watch_lo(input int cycles, output int longest);
    int run;
    run = 0;
    longest = 0;
    repeat (cycles) begin
      @(posedge i_clk_sys);
      run = (i_tx_line === 1'b0) ? run + 1 : 0;
      if (run > longest) longest = run;
    end
  endtask : watch_lo
  // one frame: start, 8 data lsb first, stop; line left at mark
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_rx_line <= f[i];
      repeat (SCICT_BIT_CYC) @(posedge i_clk_sys);
    end
  endtask : send_byte
endmodule : scict_remote

// [dv/tb_sci_control_two.sv]
// tb_sci_control_two: self-checking bench for the control-two block
// assumes: avalon master tasks below, remote peer on the serial lines
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_sci_control_two
  import scict_pkg::*;
;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [3:0] i_avs_address = 4'h0;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [3:0] i_avs_byteenable = 4'h0;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  scict_stat_t i_stat = 5'h10;
  logic i_addr_mark = 1'b0;
  logic i_rx_pin, o_irq, o_tx_pin, o_tx_oe, o_rcv_active, o_tx_active, tx_line, irq_a;
  logic [31:0] q;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  // enables, flags, expected irq
  logic [13:0] rows [10] = '{{8'h80, 5'h10, 1'b1}, {8'h00, 5'h10, 1'b0}, {8'h40, 5'h08, 1'b1},
    {8'h80, 5'h08, 1'b0}, {8'h20, 5'h04, 1'b1}, {8'h20, 5'h01, 1'b1}, {8'h10, 5'h04, 1'b0},
    {8'h10, 5'h02, 1'b1}, {8'h70, 5'h10, 1'b0}, {8'hf0, 5'h00, 1'b0}};
  assign tx_line = o_tx_oe ? o_tx_pin : 1'b1; // pull-up when released
  scict_top dut_u (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_stat(i_stat), .i_addr_mark(i_addr_mark), .i_rx_pin(i_rx_pin), .o_irq(o_irq), .o_tx_pin(o_tx_pin),
    .o_tx_oe(o_tx_oe), .o_rcv_active(o_rcv_active), .o_tx_active(o_tx_active));
  scict_remote remote_u (.i_clk_sys(i_clk_sys), .i_tx_line(tx_line), .o_rx_line(i_rx_pin));
  always #25 i_clk_sys = ~i_clk_sys;
  // hang guard, a little above the roughly 90k cycles the tests take
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 98000) begin
      err_count++;
      report_and_stop();
    end
  end
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // one avalon transfer; holds everything until waitrequest is seen low
  task automatic bus_xfer(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_byteenable <= b;
    do begin
      @(posedge i_clk_sys);
    end while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    @(posedge i_clk_sys);
  endtask : bus_xfer
  // bounded wait for the frame flag to reach v, cycles left in n
  task automatic wait_act(input logic v);
    n = 0;
    while (o_tx_active !== v && n < 30000) begin
      @(posedge i_clk_sys);
      n++;
    end
    if (n == 30000) err_count++;
  endtask : wait_act
  task automatic settle;
    repeat (3) @(posedge i_clk_sys);
  endtask : settle
  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    @(posedge i_clk_sys);
    bus_xfer(1'b0, SCICT_OFF_CTRL2, 32'h0, 4'hf);
    `CHK(q[7:0], SCICT_CTRL2_RST)
    `CHK(o_tx_oe, 1'b0)
    bus_xfer(1'b1, SCICT_OFF_CTRL2, 32'h0000_00f6, 4'h1);
    bus_xfer(1'b1, 4'h6, 32'h0000_00ff, 4'hf);
    bus_xfer(1'b0, 4'h6, 32'h0, 4'hf);
    `CHK(q, 32'h0)
    bus_xfer(1'b0, SCICT_OFF_CTRL2, 32'h0, 4'hf);
    `CHK(q[7:0], 8'hf6)
    $display("register access test done");
    // interrupt gating table; events cleared so only live flags count
    for (int r = 0; r < 10; r++) begin
      bus_xfer(1'b1, SCICT_OFF_CTRL2, {24'h0, rows[r][13:6]}, 4'h1);
      i_stat <= rows[r][5:1];
      settle();
      bus_xfer(1'b1, SCICT_OFF_EVT, 32'h0000_000f, 4'h1);
      settle();
      `CHK(o_irq, rows[r][0])
    end
    $display("interrupt gating test done");
    // sticky event: mask flip must change irq, write-one clears it
    bus_xfer(1'b1, SCICT_OFF_CTRL2, 32'h0, 4'h1);
    i_stat <= 5'h00;
    bus_xfer(1'b1, SCICT_OFF_EVT, 32'h0000_000f, 4'h1);
    i_stat <= 5'h10;
    @(posedge i_clk_sys);
    i_stat <= 5'h00;
    settle();
    irq_a = o_irq;
    bus_xfer(1'b0, SCICT_OFF_EVT, 32'h0, 4'hf);
    `CHK(q[3], 1'b1)
    bus_xfer(1'b1, SCICT_OFF_EVT, 32'h0000_0f00, 4'h2);
    settle();
    `CHK(irq_a ^ o_irq, 1'b1)
    bus_xfer(1'b1, SCICT_OFF_EVT, 32'h0000_0008, 4'h1);
    settle();
    `CHK(o_irq, 1'b0)
    $display("sticky event test done");
    // transmit with data pending; peer sends a byte first so mute works later
    bus_xfer(1'b1, SCICT_OFF_CTRL2, 32'h0000_000c, 4'h1);
    fork
      remote_u.send_byte(8'h5a);
    join_none
    wait_act(1'b1);
    `CHK(n > SCICT_BIT_CYC - 8 && n < SCICT_BIT_CYC + 8, 1'b1)
    `CHK(o_tx_oe, 1'b1)
    `CHK(o_rcv_active, 1'b1)
    // enable pulse mid-word, re-enabled with mute: idle line after the peer's byte wakes it
    bus_xfer(1'b1, SCICT_OFF_CTRL2, 32'h0000_0004, 4'h1);
    bus_xfer(1'b1, SCICT_OFF_CTRL2, 32'h0000_000e, 4'h1);
    wait_act(1'b0);
    wait_act(1'b1);
    `CHK(n >= SCICT_FRAME_BITS * SCICT_BIT_CYC - 8, 1'b1)
    bus_xfer(1'b0, SCICT_OFF_CTRL2, 32'h0, 4'hf);
    `CHK(q[1], 1'b0)
    `CHK(o_rcv_active, 1'b1)
    $display("transmit enable test done");
    // one break frame after the current word, then back to marking
    i_stat <= 5'h10;
    bus_xfer(1'b1, SCICT_OFF_CTRL2, 32'h0000_000d, 4'h1);
    wait_act(1'b0);
    bus_xfer(1'b1, SCICT_OFF_CTRL2, 32'h0000_000c, 4'h1);
    remote_u.watch_lo(SCICT_FRAME_BITS * SCICT_BIT_CYC + 40, n);
    `CHK(n >= SCICT_FRAME_BITS * SCICT_BIT_CYC - 8, 1'b1)
    remote_u.watch_lo(SCICT_BIT_CYC, n);
    `CHK(n == 0, 1'b1)
    $display("break test done");
    // mute, then wake by address mark only when that method is chosen
    bus_xfer(1'b1, SCICT_OFF_CTRL2, 32'h0000_000e, 4'h1);
    settle();
    `CHK(o_rcv_active, 1'b0)
    for (int m = 0; m < 2; m++) begin
      bus_xfer(1'b1, SCICT_OFF_CTRL1, {28'h0, m[0], 3'h0}, 4'h1);
      i_addr_mark <= 1'b1;
      @(posedge i_clk_sys);
      i_addr_mark <= 1'b0;
      settle();
      bus_xfer(1'b0, SCICT_OFF_CTRL2, 32'h0, 4'hf);
      `CHK(q[1], ~m[0])
    end
    settle();
    `CHK(o_rcv_active, 1'b1)
    $display("mute wake test done");
    report_and_stop();
  end
endmodule : tb_sci_control_two
